// ### include/mscr_pkg.sv
package mscr_pkg;
	// ****************************************
	// geometry
	// ****************************************
	localparam int SLOTS = 4;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	// ****************************************
	// register offsets inside the a16 window
	// ****************************************
	localparam logic [15:0] OFF_SLOT_A = 16'h00C3;
	localparam logic [15:0] OFF_SLOT_B = 16'h01C3;
	localparam logic [15:0] OFF_SLOT_C = 16'h02C3;
	localparam logic [15:0] OFF_SLOT_D = 16'h03C3;
	localparam logic [15:0] OFF_IRQ_A = 16'h00C1;
	localparam logic [15:0] OFF_SLOT_STEP = 16'h0100;
	// ****************************************
	// field positions and reset values
	// ****************************************
	localparam int BIT_RESET = 7;
	localparam int BIT_ERROR = 2;
	localparam int BIT_IRQ1 = 1;
	localparam int BIT_IRQ0 = 0;
	localparam int IRQ0_LSB = 0;
	localparam int IRQ1_LSB = 4;
	localparam logic [7:0] CTRL_RESET_VAL = 8'h00;
	localparam logic [2:0] IRQ_LEVEL_OFF = 3'h0;
	localparam logic [3:0] SEL_LAST_REG = 4'h7;
	// ****************************************
	// module reset pulse timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 40;
	localparam int MOD_RESET_NS = 200000;
	localparam int MOD_RESET_CYC = (MOD_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic sel;
		logic wr;
		logic [15:0] addr;
		logic [7:0] wdata;
	} mscr_req_t;
	typedef struct packed {
		logic error_n;
		logic irq1_n;
		logic irq0_n;
	} mscr_mod_stat_t;
endpackage

// ### rtl/mscr_slot_regs.sv
`timescale 1ns/10ps
// Behaviour
// - four slot control registers at a16 offsets 0x00C3..0x03C3
// - registers answer only while map selector is 0 to 7
// - writing 1 to bit 7 starts module reset; reads 0 after reset
// - bit 7 stays 1 during reset, hardware clears it on completion
// - reading bit 7 returns live reset progress for polling
// - bit 2 read-only, 1 while module error line active, resets 0
// - bits 1 and 0 read-only, follow module irq lines 1 and 0
// - selector 8 to F disables registers, range goes to module id space
// - irq level 000 disables forwarding; any of 001 to 111 forwards the line on its irq_fwd_o bit while selector is 0 to 7
module mscr_slot_regs #(
	parameter int RESET_CYC = mscr_pkg::MOD_RESET_CYC
) (
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic [3:0] register_map_selector_i,
	input wire mscr_pkg::mscr_req_t req_i,
	input wire logic [2:0] irq_level_a0_i,
	input wire logic [2:0] irq_level_a1_i,
	input wire logic [2:0] irq_level_b0_i,
	input wire logic [2:0] irq_level_b1_i,
	input wire logic [2:0] irq_level_c0_i,
	input wire logic [2:0] irq_level_c1_i,
	input wire logic [2:0] irq_level_d0_i,
	input wire logic [2:0] irq_level_d1_i,
	input wire mscr_pkg::mscr_mod_stat_t mod_stat_a_i,
	input wire mscr_pkg::mscr_mod_stat_t mod_stat_b_i,
	input wire mscr_pkg::mscr_mod_stat_t mod_stat_c_i,
	input wire mscr_pkg::mscr_mod_stat_t mod_stat_d_i,
	output logic [7:0] rdata_o,
	output logic ack_o,
	output logic id_space_sel_o,
	output logic [3:0] mod_reset_n_o,
	output logic [7:0] irq_fwd_o
);
	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [3:0] sel_s1, sel_s2;
	logic [11:0] stat_s1, stat_s2;
	wire logic [11:0] stat_raw = {mod_stat_d_i, mod_stat_c_i, mod_stat_b_i, mod_stat_a_i};
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sel_s1 <= 4'hF;
			sel_s2 <= 4'hF;
			stat_s1 <= 12'hFFF;
			stat_s2 <= 12'hFFF;
		end else begin
			sel_s1 <= register_map_selector_i;
			sel_s2 <= sel_s1;
			stat_s1 <= stat_raw;
			stat_s2 <= stat_s1;
		end
	end
	// ****************************************
	// decode
	// ****************************************
	function automatic logic [1:0] slot_of(input logic [15:0] a);
		return a[9:8];
	endfunction
	wire logic regs_on = (sel_s2 <= mscr_pkg::SEL_LAST_REG);
	wire logic ctrl_hit = req_i.sel && (req_i.addr[15:10] == 6'h00)
		&& (req_i.addr[7:0] == mscr_pkg::OFF_SLOT_A[7:0]);
	wire logic hi_range = req_i.sel && (req_i.addr[7:6] == 2'h3);
	wire logic [1:0] slot = slot_of(req_i.addr);
	wire logic take = ctrl_hit && regs_on;
	wire logic [3:0] start_vec = (take && req_i.wr && req_i.wdata[mscr_pkg::BIT_RESET])
		? (4'h1 << slot) : 4'h0;
	// ****************************************
	// per-slot reset engines
	// ****************************************
	logic [3:0] busy;
	logic [3:0] rst_n;
	genvar g;
	generate
		for (g = 0; g < mscr_pkg::SLOTS; g++) begin : g_slot
			mscr_slot_reset #(.RESET_CYC(RESET_CYC)) u_rst (
				.core_clk_i(core_clk_i),
				.rstn_i(rstn_i),
				.start_i(start_vec[g]),
				.busy_o(busy[g]),
				.mod_reset_n_o(rst_n[g])
			);
		end
	endgenerate
	// ****************************************
	// read data
	// ****************************************
	wire mscr_pkg::mscr_mod_stat_t st = stat_s2[slot*3 +: 3];
	wire logic [7:0] ctrl_word = {busy[slot], 4'h0, !st.error_n, !st.irq1_n, !st.irq0_n};
	wire logic [23:0] lv = {irq_level_d1_i, irq_level_d0_i, irq_level_c1_i, irq_level_c0_i,
		irq_level_b1_i, irq_level_b0_i, irq_level_a1_i, irq_level_a0_i};
	logic [7:0] next_fwd;
	always_comb begin
		next_fwd = 8'h00;
		for (int i = 0; i < 8; i++) begin
			next_fwd[i] = (lv[i*3 +: 3] != mscr_pkg::IRQ_LEVEL_OFF) && !stat_s2[(i/2)*3 + (i%2 == 0 ? 0 : 1)];
		end
	end
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rdata_o <= mscr_pkg::CTRL_RESET_VAL;
			ack_o <= 1'b0;
			id_space_sel_o <= 1'b0;
			mod_reset_n_o <= 4'hF;
			irq_fwd_o <= 8'h00;
		end else begin
			rdata_o <= take ? ctrl_word : 8'h00;
			ack_o <= take;
			id_space_sel_o <= hi_range && !regs_on;
			mod_reset_n_o <= rst_n;
			irq_fwd_o <= regs_on ? next_fwd : 8'h00;
		end
	end
	// ****************************************
	// checks
	// ****************************************
	AST_START: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		start_vec[0] && !busy[0] |=> busy[0]) else $error("write did not start reset");
	AST_POLL: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		take && !req_i.wr |=> rdata_o[7] == $past(busy[slot])) else $error("bad reset bit read");
	AST_HOLD: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		$rose(busy[1]) |-> busy[1][*4]) else $error("reset bit dropped early");
	AST_IDOFF: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		regs_on |=> !id_space_sel_o) else $error("id space selected while registers on");
	AST_PIN: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		busy[2] |=> !mod_reset_n_o[2]) else $error("module reset not driven");
	AST_RSVD: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		rdata_o[6:3] == 4'h0) else $error("reserved bits not zero");
	AST_OFF: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		!regs_on |=> !ack_o) else $error("register answered while disabled");
	AST_ERR: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		take && !st.error_n |=> rdata_o[2]) else $error("error bit wrong");
	AST_IRQ: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		take |=> rdata_o[1:0] == $past({!st.irq1_n, !st.irq0_n})) else $error("irq bits wrong");
	AST_LVL: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		irq_level_a0_i == 3'h0 |=> !irq_fwd_o[0]) else $error("disabled irq forwarded");
	COV_WR: cover property (@(posedge core_clk_i) start_vec != 4'h0);
	COV_DONE: cover property (@(posedge core_clk_i) $fell(busy[0]));
	COV_ID: cover property (@(posedge core_clk_i) id_space_sel_o);
	COV_POLL: cover property (@(posedge core_clk_i) take && !req_i.wr && busy[slot]);
endmodule

// ### rtl/mscr_slot_reset.sv
`timescale 1ns/10ps
module mscr_slot_reset #(
	parameter int RESET_CYC = 5000
) (
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic start_i,
	output logic busy_o,
	output logic mod_reset_n_o
);
	logic [31:0] count;
	logic busy;
	wire logic last = (count == 32'h00000001);
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			busy <= 1'b0;
			count <= 32'h00000000;
		end else if (!busy && start_i) begin
			busy <= 1'b1;
			count <= 32'(RESET_CYC);
		end else if (busy) begin
			busy <= !last;
			count <= count - 32'h00000001;
		end
	end
	// reset line follows busy so host polling and the module see the same window
	assign busy_o = busy;
	assign mod_reset_n_o = !busy;
	// a counter carries the long window so the property stays bounded for any RESET_CYC
	AST_LENGTH: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		busy && !last |=> busy) else $error("reset ended early");
	AST_END: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		busy && last |=> !busy) else $error("reset did not end");
endmodule

// ### tb/module_slot_control_regs_tb.sv
`timescale 1ns/10ps
// ****************************************
// host side bench for the slot control registers
// ****************************************
module module_slot_control_regs_tb;
	logic core_clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic [3:0] sel = 4'h0;
	mscr_pkg::mscr_req_t req = '0;
	logic [23:0] lvl = '0;
	logic [11:0] line_on = '0;
	logic [11:0] stat;
	logic [7:0] rdata, fwd, rd;
	logic ack, id_sel, ak;
	logic [3:0] mrst_n;
	int num_errors = 0;
	int cmp_count = 0;
	int n;
	initial begin
		forever #20 core_clk_i = ~core_clk_i;
	end
	// short module reset keeps the polling loops brief
	mscr_slot_regs #(.RESET_CYC(4)) DUT (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
		.register_map_selector_i(sel), .req_i(req), .irq_level_a0_i(lvl[2:0]), .irq_level_a1_i(lvl[5:3]),
		.irq_level_b0_i(lvl[8:6]), .irq_level_b1_i(lvl[11:9]), .irq_level_c0_i(lvl[14:12]),
		.irq_level_c1_i(lvl[17:15]), .irq_level_d0_i(lvl[20:18]), .irq_level_d1_i(lvl[23:21]),
		.mod_stat_a_i(stat[2:0]), .mod_stat_b_i(stat[5:3]), .mod_stat_c_i(stat[8:6]),
		.mod_stat_d_i(stat[11:9]), .rdata_o(rdata), .ack_o(ack), .id_space_sel_o(id_sel),
		.mod_reset_n_o(mrst_n), .irq_fwd_o(fwd));
	mscr_mod_model u_mod (.mod_reset_n_i(mrst_n), .line_on_i(line_on), .stat_o(stat));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic acc(input logic wr, input logic [15:0] a, input logic [7:0] wd);
		@(negedge core_clk_i);
		req = '{sel: 1'b1, wr: wr, addr: a, wdata: wd};
		@(negedge core_clk_i);
		rd = rdata;
		ak = ack;
		req.sel = 1'b0;
	endtask
	function automatic logic [15:0] slot_addr(input int s);
		return mscr_pkg::OFF_SLOT_A + 16'(s) * mscr_pkg::OFF_SLOT_STEP;
	endfunction
	function automatic logic [7:0] exp_fwd();
		logic [7:0] f;
		for (int i = 0; i < 8; i++) begin
			f[i] = line_on[3*(i/2)+(i%2)] && (lvl[3*i+:3] != 3'h0);
		end
		return f;
	endfunction
	task automatic tally_and_finish();
		$display("errors=%0d compares=%0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		void'($urandom(32'h788e16ab));
		repeat (3) @(negedge core_clk_i);
		rstn_i = 1'b1;
		repeat (3) @(negedge core_clk_i);
		for (int s = 0; s < 4; s++) begin
			acc(1'b0, slot_addr(s), 8'h00);
			chk({rd[7:1], ak}, 8'h01);
			chk(rd, 8'h00);
			chk({7'h00, id_sel}, 8'h00);
		end
		for (int i = 0; i < 12; i++) begin
			line_on = 12'($urandom());
			lvl = (i == 0) ? 24'h0 : 24'($urandom());
			sel = (i == 1) ? 4'h7 : 4'($urandom_range(7));
			repeat (5) @(negedge core_clk_i);
			chk(fwd, exp_fwd());
			for (int s = 0; s < 4; s++) begin
				acc(1'b1, slot_addr(s), 8'($urandom()) & 8'h7F);
				acc(1'b0, slot_addr(s), 8'h00);
				chk(rd, {5'h00, line_on[3*s+:3]});
			end
		end
		line_on = '0;
		for (int s = 0; s < 4; s++) begin
			acc(1'b1, slot_addr(s), 8'h80);
			chk({7'h00, ak}, 8'h01);
			acc(1'b0, slot_addr(s), 8'h00);
			chk(rd, 8'h80);
			chk({4'h0, mrst_n}, {4'h0, ~(4'h1 << s)});
			n = 0;
			while (rd[7] !== 1'b0 && n < 20) begin
				acc(1'b0, slot_addr(s), 8'h00);
				n++;
			end
			chk(8'(n < 20), 8'h01);
			if (n >= 20) tally_and_finish();
			chk({4'h0, mrst_n}, 8'h0F);
		end
		for (int v = 8; v < 16; v++) begin
			sel = 4'(v);
			repeat (3) @(negedge core_clk_i);
			acc(1'b1, slot_addr(v % 4), 8'h80);
			chk({6'h00, ak, id_sel}, 8'h01);
			repeat (2) @(negedge core_clk_i);
			chk({4'h0, mrst_n}, 8'h0F);
		end
		tally_and_finish();
	end
endmodule

// ### tb/mscr_mod_model.sv
`timescale 1ns/10ps
// ****************************************
// four mezzanine modules seen from their slot pins
// ****************************************
module mscr_mod_model (
	input wire logic [3:0] mod_reset_n_i,
	input wire logic [11:0] line_on_i,
	output logic [11:0] stat_o
);
	// lines fall back to their pull-up while a module is held in reset, so nothing is flagged then
	for (genvar s = 0; s < 4; s++) begin : g_slot
		assign stat_o[3*s+:3] = mod_reset_n_i[s] ? ~line_on_i[3*s+:3] : 3'h7;
	end
endmodule
